/* File: rtl/rsc_top.sv */
// Reset source control: gathers reset requests, keeps the cause flags
// and picks the fetch vector used after reset.
// Assumes APB access from the core, on-chip sources on pclk, and the
// pin and analog detectors asynchronous to pclk.
//
// Notes on behaviour
// [RULE1] Pin enable set: pin is active-low reset
// [RULE2] Power-on sequence forces pin to reset
// [RULE3] Only power-on overrides pin function
// [RULE4] Board must not hold pin low
// [RULE5] Six sources raise system reset
// [RULE6] Own flag per source, write 0 clears
// [RULE7] Power-on sets power and brownout flags only
// [RULE8] Watchdog reset flags like power-on
// [RULE9] Other resets keep earlier flags set
// [RULE10] Pin flag bit 0, set if pin held
// [RULE11] Software flag bit 1
// [RULE12] Watchdog flag bit 2, config bit 7
// [RULE13] Enabled break resets, sets bit 3
// [RULE14] Power-on flag bit 4 sticky
// [RULE15] Brownout reset flag bit 5 sticky
// [RULE16] Brownout interrupt flag bit 6, bit 7 reserved
// [RULE17] Power-on value reads 0x30
// [RULE18] Fetch starts at zero or boot address
// [RULE19] Boot address is vector byte then 00
// [RULE20] Boot address after break or boot bit
// [RULE21] Brownout interrupt enable gives interrupt
// [RULE22] Pin synchronised by two flops
module rsc_top #(
  parameter int unsigned HOLD_CYC = rsc_pkg::RST_HOLD_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset sources
  input  wire logic        shared_input_pin_n,
  input  wire logic        power_on_detect,
  input  wire logic        brownout_detect,
  input  wire logic        watchdog_reset_req,
  input  wire logic        uart_break_detect,
  // Non-volatile configuration
  input  wire logic        reset_pin_enable,
  input  wire logic [7:0]  user_config_byte,
  input  wire logic [7:0]  boot_status_byte,
  input  wire logic [7:0]  boot_vector,
  // Results
  output logic             system_reset,
  output logic             brownout_irq,
  output logic             pin_digital_in,
  output logic      [15:0] fetch_address
);

  // ********************************************************************
  // Synchronisers
  // ********************************************************************
  logic               pin_meta_ff;
  logic               pin_sync_ff;
  logic               por_meta_ff;
  logic               por_sync_ff;
  logic               bo_meta_ff;
  logic               bo_sync_ff;
  logic               bo_dly_ff;

  // Pin idles high, so its stages reset high and no false edge follows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
    end else begin
      pin_meta_ff <= shared_input_pin_n; // RULE22
      pin_sync_ff <= pin_meta_ff;        // RULE22
    end
  end

  // Power-on detector idles low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_meta_ff <= 1'b0;
      por_sync_ff <= 1'b0;
    end else begin
      por_meta_ff <= power_on_detect;
      por_sync_ff <= por_meta_ff;
    end
  end

  // Brownout detector idles low; the third stage feeds the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bo_meta_ff  <= 1'b0;
      bo_sync_ff  <= 1'b0;
      bo_dly_ff   <= 1'b0;
    end else begin
      bo_meta_ff  <= brownout_detect;
      bo_sync_ff  <= bo_meta_ff;
      bo_dly_ff   <= bo_sync_ff;
    end
  end

  // ********************************************************************
  // Power-on sequence
  // ********************************************************************
  rsc_pkg::rsc_por_e  por_st_ff;
  rsc_pkg::rsc_por_e  nxt_por_st;
  logic               pin_low;
  logic               por_seq;

  assign pin_low = ~pin_sync_ff;
  assign por_seq = (por_st_ff != rsc_pkg::POR_RUN);

  // Hold while detector is active, then while the pin stays low
  always_comb begin
    nxt_por_st = por_st_ff;
    unique case (por_st_ff)
      rsc_pkg::POR_HOLD: begin
        if (!por_sync_ff) begin
          nxt_por_st = pin_low ? rsc_pkg::POR_PIN : rsc_pkg::POR_RUN; // RULE2
        end
      end
      rsc_pkg::POR_PIN: begin
        if (por_sync_ff) begin
          nxt_por_st = rsc_pkg::POR_HOLD;
        end else if (!pin_low) begin
          nxt_por_st = rsc_pkg::POR_RUN; // RULE4
        end
      end
      rsc_pkg::POR_RUN: begin
        if (por_sync_ff) begin
          nxt_por_st = rsc_pkg::POR_HOLD;
        end
      end
      default: nxt_por_st = rsc_pkg::POR_HOLD;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_st_ff <= rsc_pkg::POR_HOLD;
    end else begin
      por_st_ff <= nxt_por_st;
    end
  end

  // ********************************************************************
  // APB decode
  // ********************************************************************
  logic               acc_wr;
  logic               hit_cause;
  logic               hit_ctrl;
  logic               hit_stat;
  logic               hit_any;

  assign hit_cause = (paddr == rsc_pkg::ADDR_CAUSE);
  assign hit_ctrl  = (paddr == rsc_pkg::ADDR_CTRL);
  assign hit_stat  = (paddr == rsc_pkg::ADDR_STAT);
  assign hit_any   = hit_cause | hit_ctrl | hit_stat;
  assign acc_wr    = psel & penable & pready & pwrite;

  // ********************************************************************
  // Control register
  // ********************************************************************
  rsc_pkg::rsc_ctrl_s ctrl_ff;
  logic               sw_req_ff;

  // Enables are stored until software rewrites them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= '0;
    end else if (acc_wr && hit_ctrl) begin
      ctrl_ff.brk_en    <= pwdata[rsc_pkg::CTRL_BRKEN];
      ctrl_ff.bo_irq_en <= pwdata[rsc_pkg::CTRL_BOIRQ];
    end
  end

  // The software reset bit is never stored; it pulses for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_req_ff <= 1'b0;
    end else begin
      sw_req_ff <= acc_wr & hit_ctrl & pwdata[rsc_pkg::CTRL_SWRST]; // RULE11
    end
  end

  // ********************************************************************
  // Source gathering
  // ********************************************************************
  rsc_pkg::rsc_src_s  src;
  logic               pin_is_rst;
  logic               bo_evt;
  logic               any_src;

  // Pin is a reset input when enabled or during power-on
  assign pin_is_rst = reset_pin_enable | por_seq;         // RULE1 RULE2 RULE3

  // Gather every request except power-on into one carrier, driven from one process
  always_comb begin
    src     = '0;
    src.pin = pin_is_rst & pin_low;                       // RULE1
    src.sw  = sw_req_ff;
    src.wdt = watchdog_reset_req;
    src.brk = uart_break_detect & ctrl_ff.brk_en;         // RULE13
    // Brownout resets only while its interrupt is disabled
    src.bo  = bo_sync_ff & ~ctrl_ff.bo_irq_en;            // RULE21
  end

  assign bo_evt     = bo_sync_ff & ~bo_dly_ff & ctrl_ff.bo_irq_en; // RULE21
  assign any_src    = por_seq | (|src);                   // RULE5

  // ********************************************************************
  // System reset stretch
  // ********************************************************************
  logic [15:0]        hold_cnt_ff;
  logic               sys_rst_ff;

  // Reset stands while a source is active and HOLD_CYC cycles after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_ff <= 16'(HOLD_CYC);
      sys_rst_ff  <= 1'b1;
    end else begin
      if (any_src) begin
        hold_cnt_ff <= 16'(HOLD_CYC); // RULE5
      end else if (hold_cnt_ff != 16'h0000) begin
        hold_cnt_ff <= hold_cnt_ff - 16'h0001;
      end
      sys_rst_ff <= any_src | (hold_cnt_ff > 16'h0001); // RULE5
    end
  end

  // ********************************************************************
  // Reset cause flags
  // ********************************************************************
  logic [7:0]         cause_ff;
  logic [7:0]         set_mask;
  logic [7:0]         clr_mask;
  logic [7:0]         wdt_val;

  // Events raising their own flag
  always_comb begin
    set_mask = 8'h00;
    set_mask[rsc_pkg::FLG_PIN]  = src.pin & ~por_seq;     // RULE10
    if (por_st_ff == rsc_pkg::POR_PIN) begin
      set_mask[rsc_pkg::FLG_PIN] = 1'b1;                  // RULE10
    end
    set_mask[rsc_pkg::FLG_SW]   = src.sw;                 // RULE11
    set_mask[rsc_pkg::FLG_BRK]  = src.brk;                // RULE13
    set_mask[rsc_pkg::FLG_BORST] = src.bo;                // RULE15
    set_mask[rsc_pkg::FLG_BOIRQ] = bo_evt;                // RULE16
  end

  // Writing 0 clears a flag; bit 7 is never stored
  assign clr_mask = (acc_wr && hit_cause) ? (~pwdata[7:0] & rsc_pkg::CAUSE_MASK)
                                          : 8'h00;        // RULE6

  // Watchdog flag only when the user configuration asks for it
  always_comb begin
    wdt_val = rsc_pkg::CAUSE_POR;                         // RULE8
    wdt_val[rsc_pkg::FLG_WDT] = user_config_byte[rsc_pkg::UCFG_WDT]; // RULE12
  end

  // Power-on and watchdog replace the flags; others accumulate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff <= rsc_pkg::CAUSE_POR;                     // RULE17
    end else if (por_st_ff == rsc_pkg::POR_HOLD) begin
      cause_ff <= rsc_pkg::CAUSE_POR;                     // RULE7 RULE14
    end else if (src.wdt) begin
      cause_ff <= wdt_val;                                // RULE8
    end else begin
      cause_ff <= (cause_ff & ~clr_mask) | set_mask;      // RULE6 RULE9
    end
  end

  // ********************************************************************
  // Fetch vector
  // ********************************************************************
  logic               brk_cause_ff;
  logic [15:0]        fetch_ff;
  logic               use_boot;

  // Remember whether the latest reset came from a break
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_cause_ff <= 1'b0;
    end else if (src.brk) begin
      brk_cause_ff <= 1'b1;                               // RULE20
    end else if (any_src) begin
      brk_cause_ff <= 1'b0;
    end
  end

  assign use_boot = brk_cause_ff | boot_status_byte[rsc_pkg::BOOT_BIT]; // RULE20

  // Vector follows the sources while reset stands, then freezes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_ff <= rsc_pkg::FETCH_ZERO;
    end else if (sys_rst_ff) begin
      fetch_ff <= use_boot ? {boot_vector, rsc_pkg::BOOT_LO} // RULE19
                           : rsc_pkg::FETCH_ZERO;         // RULE18
    end
  end

  // ********************************************************************
  // Brownout interrupt and pin level
  // ********************************************************************
  logic               bo_irq_ff;
  logic               pin_lvl_ff;

  // One-cycle interrupt pulse per brownout event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bo_irq_ff <= 1'b0;
    end else begin
      bo_irq_ff <= bo_evt;                                // RULE21
    end
  end

  // Pin level stays readable whatever the pin function
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_lvl_ff <= 1'b1;
    end else begin
      pin_lvl_ff <= pin_sync_ff;                          // RULE1
    end
  end

  // ********************************************************************
  // APB answer
  // ********************************************************************
  logic [31:0]        rd_val;
  logic [31:0]        prdata_ff;
  logic               pready_ff;
  logic               pslverr_ff;

  // Read mux; reserved bits read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_cause) begin
      rd_val[7:0] = cause_ff & rsc_pkg::CAUSE_MASK;       // RULE16
    end else if (hit_ctrl) begin
      rd_val[rsc_pkg::CTRL_BRKEN] = ctrl_ff.brk_en;
      rd_val[rsc_pkg::CTRL_BOIRQ] = ctrl_ff.bo_irq_en;
    end else if (hit_stat) begin
      rd_val[15:0]                = fetch_ff;
      rd_val[rsc_pkg::STAT_INRST] = sys_rst_ff;
      rd_val[rsc_pkg::STAT_PMODE] = pin_is_rst;
      rd_val[rsc_pkg::STAT_PLVL]  = pin_sync_ff;
    end
  end

  // Answer is prepared in the setup cycle, ready on the first access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~hit_any;
      if (psel && !penable && !pwrite) begin
        prdata_ff <= rd_val;
      end
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign system_reset   = sys_rst_ff;
  assign brownout_irq   = bo_irq_ff;
  assign pin_digital_in = pin_lvl_ff;
  assign fetch_address  = fetch_ff;

endmodule : rsc_top

/* File: rtl/rsc_pkg.sv */
// Constants, register map and carrier types of the reset source control.
// Assumes a 32-bit APB slave port clocked by pclk at 40 MHz.
package rsc_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam int unsigned ADDR_W     = 12;
  localparam logic [7:0]  IDX_CAUSE  = 8'hdf;
  localparam logic [7:0]  IDX_CTRL   = 8'he0;
  localparam logic [7:0]  IDX_STAT   = 8'he1;
  // Byte address is four times the register index
  localparam logic [11:0] ADDR_CAUSE = {2'h0, IDX_CAUSE, 2'h0};
  localparam logic [11:0] ADDR_CTRL  = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_STAT  = {2'h0, IDX_STAT, 2'h0};

  // ********************************************************************
  // Field positions and values
  // ********************************************************************
  localparam int unsigned FLG_PIN    = 0;
  localparam int unsigned FLG_SW     = 1;
  localparam int unsigned FLG_WDT    = 2;
  localparam int unsigned FLG_BRK    = 3;
  localparam int unsigned FLG_PON    = 4;
  localparam int unsigned FLG_BORST  = 5;
  localparam int unsigned FLG_BOIRQ  = 6;
  localparam logic [7:0]  CAUSE_POR  = 8'h30;
  localparam logic [7:0]  CAUSE_MASK = 8'h7f;
  localparam int unsigned CTRL_SWRST = 0;
  localparam int unsigned CTRL_BOIRQ = 4;
  localparam int unsigned CTRL_BRKEN = 6;
  localparam int unsigned STAT_INRST = 16;
  localparam int unsigned STAT_PMODE = 17;
  localparam int unsigned STAT_PLVL  = 18;
  localparam int unsigned UCFG_WDT   = 7;
  localparam int unsigned BOOT_BIT   = 0;
  localparam logic [7:0]  BOOT_LO    = 8'h00;
  localparam logic [15:0] FETCH_ZERO = 16'h0000;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_MHZ     = 40;
  localparam int unsigned RST_HOLD_NS = 200;
  localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    POR_RUN  = 2'b00,
    POR_HOLD = 2'b01,
    POR_PIN  = 2'b10
  } rsc_por_e;

  typedef struct packed {
    logic brk;
    logic bo;
    logic wdt;
    logic sw;
    logic pin;
  } rsc_src_s;

  typedef struct packed {
    logic brk_en;
    logic bo_irq_en;
  } rsc_ctrl_s;

endpackage : rsc_pkg

/* File: bench/rsc_top_sva.sv */
// Port checker of the reset source control.
// Assumes a bind onto rsc_top, clocked by pclk and reset by presetn.
module rsc_top_sva (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Sources and configuration
  input wire logic        shared_input_pin_n,
  input wire logic        power_on_detect,
  input wire logic        watchdog_reset_req,
  input wire logic        reset_pin_enable,
  input wire logic [7:0]  boot_status_byte,
  input wire logic [7:0]  boot_vector,
  // Results
  input wire logic        system_reset,
  input wire logic        brownout_irq,
  input wire logic        pin_digital_in,
  input wire logic [15:0] fetch_address
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******************
  // Reset and fetch
  // ******************
  // One domain, checks held off while presetn is low
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Watchdog, power-on and enabled-pin requests reach system reset in time
  AST_WDT_RST: assert property (watchdog_reset_req |=> system_reset)
    else $error("watchdog request without system reset");
  AST_POR_RST: assert property (power_on_detect |-> ##[1:4] system_reset)
    else $error("power-on without system reset");
  AST_PIN_RST: assert property (
    (reset_pin_enable && !shared_input_pin_n) [*3] |-> ##[0:1] system_reset)
    else $error("enabled pin low without system reset");
  // Pin level is always readable three cycles late
  AST_PIN_IN: assert property ($fell(shared_input_pin_n) |-> ##3 !pin_digital_in)
    else $error("pin level not passed to digital input");
  // Fetch vector shape and update moments
  AST_FETCH_LOW: assert property (fetch_address[7:0] == 8'h00)
    else $error("fetch address low byte not zero");
  AST_FETCH_BOOT: assert property (
    system_reset && boot_status_byte[0] |=> fetch_address == {boot_vector, 8'h00})
    else $error("boot address not chosen");
  AST_FETCH_HOLD: assert property (!system_reset |=> $stable(fetch_address))
    else $error("fetch address moved outside reset");
  AST_IRQ_PULSE: assert property (brownout_irq |=> !brownout_irq)
    else $error("brownout interrupt longer than one cycle");
endmodule : rsc_top_sva

bind rsc_top rsc_top_sva i_rsc_top_sva (
  .pclk, .presetn, .shared_input_pin_n, .power_on_detect, .watchdog_reset_req,
  .reset_pin_enable, .boot_status_byte, .boot_vector, .system_reset,
  .brownout_irq, .pin_digital_in, .fetch_address
);

/* File: bench/rsc_src_model.sv */
// Model of the reset sources and the board around the pin.
// Assumes the bench calls drive_src from its main sequence.
module rsc_src_model (
  // Clock
  input  wire logic pclk,
  // Source lines
  output logic      shared_input_pin_n,
  output logic      power_on_detect,
  output logic      brownout_detect,
  output logic      watchdog_reset_req,
  output logic      uart_break_detect
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] act_ff = 5'h00;
  // Released pin sits on its pull-up; it is held low only when asked
  assign shared_input_pin_n = ~act_ff[0];
  assign power_on_detect    = act_ff[1];
  assign brownout_detect    = act_ff[2];
  assign watchdog_reset_req = act_ff[3];
  assign uart_break_detect  = act_ff[4];
  // Applies a set of sources from the next edge, waits n cycles and leaves them applied
  task automatic drive_src(input logic [4:0] m, input int n);
    @(posedge pclk);
    act_ff <= m;
    repeat (n) @(posedge pclk);
  endtask : drive_src
endmodule : rsc_src_model

/* File: bench/rsc_top_bench.sv */
// Self-checking bench of the reset source control.
// Assumes rsc_top with a short hold count and the source model beside it.
module rsc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_n, por, bo_det, wdt, brk, sys_rst, bo_irq, pin_in, err_q;
  logic        pin_en = 1'h1;
  logic [7:0]  ucfg = 8'h80;
  logic [7:0]  bstat = 8'h00;
  logic [7:0]  bvec = 8'h5a;
  logic [15:0] fetch;
  logic [31:0] rd_q;
  int          n_errors = 0;
  int          checks_done = 0;
  int          n_irq = 0;

  // ******************
  // Design and sources
  // ******************
  rsc_top #(.HOLD_CYC(2)) i_rsc_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .shared_input_pin_n(pin_n), .power_on_detect(por),
    .brownout_detect(bo_det), .watchdog_reset_req(wdt), .uart_break_detect(brk),
    .reset_pin_enable(pin_en), .user_config_byte(ucfg), .boot_status_byte(bstat),
    .boot_vector(bvec), .system_reset(sys_rst), .brownout_irq(bo_irq),
    .pin_digital_in(pin_in), .fetch_address(fetch)
  );
  rsc_src_model i_rsc_src_model (
    .pclk, .shared_input_pin_n(pin_n), .power_on_detect(por),
    .brownout_detect(bo_det), .watchdog_reset_req(wdt), .uart_break_detect(brk)
  );
  // 40 MHz clock and interrupt pulse counter
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (bo_irq === 1'h1) n_irq++;

  // ******************
  // Tasks
  // ******************
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high; only the watchdog ends a wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd_q, e);
  endtask : rd
  // Waits for system reset to end, bounded
  task automatic settle();
    int k;
    k = 0;
    repeat (4) @(posedge pclk);
    while (sys_rst !== 1'h0 && k < 200) begin
      k++;
      @(posedge pclk);
    end
    chk({31'h0, sys_rst}, 32'h0);
  endtask : settle
  // Raises sources for six cycles and checks after five whether reset followed
  task automatic fire(input logic [4:0] m, input logic e);
    i_rsc_src_model.drive_src(m, 5);
    chk({31'h0, sys_rst}, {31'h0, e});
    i_rsc_src_model.drive_src(5'h00, 1);
    settle();
  endtask : fire

  // ******************
  // Sequence
  // ******************
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    settle();
    rd(rsc_pkg::ADDR_CAUSE, 32'h30);
    apb(1'h1, rsc_pkg::ADDR_CAUSE, 32'hff);
    rd(rsc_pkg::ADDR_CAUSE, 32'h30);
    apb(1'h1, rsc_pkg::ADDR_CAUSE, 32'h0);
    rd(rsc_pkg::ADDR_CAUSE, 32'h0);
    apb(1'h0, 12'h000, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    apb(1'h1, rsc_pkg::ADDR_CTRL, 32'h1);
    settle();
    rd(rsc_pkg::ADDR_CAUSE, 32'h02);
    rd(rsc_pkg::ADDR_STAT, 32'h0006_0000);
    fire(5'h01, 1'h1);
    rd(rsc_pkg::ADDR_CAUSE, 32'h03);
    @(posedge pclk);
    pin_en <= 1'h0;
    fire(5'h01, 1'h0);
    rd(rsc_pkg::ADDR_STAT, 32'h0004_0000);
    apb(1'h1, rsc_pkg::ADDR_CTRL, 32'h40);
    fire(5'h10, 1'h1);
    rd(rsc_pkg::ADDR_CAUSE, 32'h0b);
    rd(rsc_pkg::ADDR_STAT, 32'h0004_5a00);
    chk({16'h0, fetch}, 32'h0000_5a00);
    fire(5'h08, 1'h1);
    rd(rsc_pkg::ADDR_CAUSE, 32'h34);
    rd(rsc_pkg::ADDR_STAT, 32'h0004_0000);
    apb(1'h1, rsc_pkg::ADDR_CAUSE, 32'h0);
    fire(5'h04, 1'h1);
    rd(rsc_pkg::ADDR_CAUSE, 32'h20);
    apb(1'h1, rsc_pkg::ADDR_CTRL, 32'h10);
    fire(5'h04, 1'h0);
    chk(n_irq, 32'h1);
    rd(rsc_pkg::ADDR_CAUSE, 32'h60);
    @(posedge pclk);
    bstat <= 8'h01;
    apb(1'h1, rsc_pkg::ADDR_CTRL, 32'h1);
    settle();
    rd(rsc_pkg::ADDR_STAT, 32'h0004_5a00);
    @(posedge pclk);
    bstat <= 8'h00;
    i_rsc_src_model.drive_src(5'h03, 5);
    i_rsc_src_model.drive_src(5'h01, 6);
    chk({31'h0, sys_rst}, 32'h1);
    chk({31'h0, pin_in}, 32'h0);
    i_rsc_src_model.drive_src(5'h00, 1);
    settle();
    rd(rsc_pkg::ADDR_CAUSE, 32'h31);
    test_done();
  end
  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    test_done();
  end
endmodule : rsc_top_bench
